// [hw/aisc_pkg.sv]
// package for the converter input select and pin configuration block
//
// Summary of operation
// - set A positive input code, bits 4-0
// - set B positive input code, bits 12-8
// - set A negative: input one, else low ref
// - set B negative bit 15, same encoding
// - unimplemented bits ignore writes, read zero
// - codes six to eight reserved on small package
// - one scan include bit per analog input
// - absent scanned input converts low reference
// - digital bit set: digital, read on, grounded
// - digital bit clear, module enabled: analog, read off, sampled
// - bit x controls input x, absent ignored
// - module disabled: all shared pins digital
// - alternate enable swaps sets A, B per sample
// - scan enable steps set A positive through mask
package aisc_pkg;

    // ------------------------------------------------------------------
    // widths and register offsets
    // ------------------------------------------------------------------
    localparam int          AISC_NUM_IN    = 13;
    localparam int          AISC_AW        = 5;
    localparam int          AISC_DW        = 16;
    localparam logic [4:0]  AISC_OFF_CHS0  = 5'h00;
    localparam logic [4:0]  AISC_OFF_CSSL  = 5'h04;
    localparam logic [4:0]  AISC_OFF_PIN_DIGITAL_MODE_BITS  = 5'h08;
    localparam logic [4:0]  AISC_OFF_CTRL  = 5'h0c;
    localparam logic [4:0]  AISC_OFF_STAT  = 5'h10;

    // ------------------------------------------------------------------
    // implemented-bit masks and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] AISC_MASK_CHS0 = 16'h9f9f;
    localparam logic [15:0] AISC_MASK_CSSL = 16'h1fff;
    localparam logic [15:0] AISC_MASK_PIN_DIGITAL_MODE_BITS = 16'h1fff;
    localparam logic [15:0] AISC_MASK_CTRL = 16'h8401;
    localparam logic [15:0] AISC_RST_REG   = 16'h0000;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          AISC_POS_A_LSB = 0;
    localparam int          AISC_NEG_A_BIT = 7;
    localparam int          AISC_POS_B_LSB = 8;
    localparam int          AISC_NEG_B_BIT = 15;
    localparam int          AISC_ALTERNATE_SAMPLE_ENABLE_BIT  = 0;
    localparam int          AISC_SCAN_BIT  = 10;
    localparam int          AISC_MDIS_BIT  = 15;
    localparam int          AISC_STAT_B    = 4;

    // ------------------------------------------------------------------
    // input codes and package variants
    // ------------------------------------------------------------------
    localparam logic [4:0]  AISC_CODE_MAX  = 5'h0c;
    localparam logic [4:0]  AISC_RSV_LO    = 5'h06;
    localparam logic [4:0]  AISC_RSV_HI    = 5'h08;
    localparam logic [12:0] AISC_EXIST_BIG = 13'h1fff;
    localparam logic [12:0] AISC_EXIST_SML = 13'h1e3f;

    // selection handed to the sampling multiplexer
    typedef struct packed {
        logic [4:0] pos_code;
        logic       neg_is_in1;
        logic       pos_is_low_reference_level;
        logic       code_invalid;
    } aisc_sel_t;

endpackage

// [hw/aisc_scan_next.sv]
// next selected scan input, ascending with wrap
`timescale 1ns/1ns
module aisc_scan_next (
    input  wire logic [aisc_pkg::AISC_NUM_IN-1:0] mask,
    input  wire logic [3:0]                       cur,
    output logic      [3:0]                       nxt
);
    import aisc_pkg::*;

    // ------------------------------------------------------------------
    // search
    // ------------------------------------------------------------------
    // the search looks at cur+1 .. cur+13 modulo 13, so cur itself is
    // found last; an empty mask holds the pointer where it is
    always_comb begin
        int unsigned idx;
        logic        found;
        idx   = 0;
        found = 1'b0;
        nxt   = cur;
        for (int i = 1; i <= AISC_NUM_IN; i++) begin
            idx = (int'(cur) + i) % AISC_NUM_IN;
            if (!found && mask[idx]) begin
                nxt   = idx[3:0];
                found = 1'b1;
            end
        end
    end

endmodule // aisc_scan_next

// [hw/aisc_pin_mode.sv]
// per-pin analog or digital mode decode
`timescale 1ns/1ns
module aisc_pin_mode (
    input  wire logic [aisc_pkg::AISC_NUM_IN-1:0] cfg_digital,
    input  wire logic [aisc_pkg::AISC_NUM_IN-1:0] exists,
    input  wire logic                             module_off,
    output logic      [aisc_pkg::AISC_NUM_IN-1:0] digital,
    output logic      [aisc_pkg::AISC_NUM_IN-1:0] read_en,
    output logic      [aisc_pkg::AISC_NUM_IN-1:0] mux_gnd
);
    import aisc_pkg::*;

    // ------------------------------------------------------------------
    // one slice per analog input
    // ------------------------------------------------------------------
    // an absent pin keeps its bit writable but drives nothing here
    for (genvar g = 0; g < AISC_NUM_IN; g++) begin : g_pin
        assign digital[g] = exists[g]
                          & (module_off | cfg_digital[g]);
        assign read_en[g] = digital[g];
        assign mux_gnd[g] = digital[g];
    end

endmodule // aisc_pin_mode

// [hw/aisc_top.sv]
// converter input select, scan and pin configuration block
`timescale 1ns/1ns
module aisc_top #(
    parameter bit SMALL_PKG = 1'b0
) (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic [aisc_pkg::AISC_AW-1:0]     reg_addr,
    input  wire logic [aisc_pkg::AISC_DW-1:0]     reg_wdata,
    input  wire logic                             reg_we,
    input  wire logic                             reg_re,
    output logic      [aisc_pkg::AISC_DW-1:0]     reg_rdata,
    input  wire logic                             sample_done,
    output aisc_pkg::aisc_sel_t                   ch_zero_sel,
    output logic                                  sample_is_b,
    output logic      [aisc_pkg::AISC_NUM_IN-1:0] pin_digital,
    output logic      [aisc_pkg::AISC_NUM_IN-1:0] pin_read_en,
    output logic      [aisc_pkg::AISC_NUM_IN-1:0] pin_mux_gnd
);
    import aisc_pkg::*;

    localparam logic [12:0] EXIST = SMALL_PKG ? AISC_EXIST_SML
                                              : AISC_EXIST_BIG;

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [15:0] channel0_input_select;
    logic [15:0] input_scan_select_low;
    logic [15:0] analog_pin_config_low;
    logic [15:0] converter_control;
    logic [15:0] next_channel0_input_select;
    logic [15:0] next_input_scan_select_low;
    logic [15:0] next_analog_pin_config_low;
    logic [15:0] next_converter_control;
    logic [15:0] next_reg_rdata;
    logic [3:0]  scan_ptr;
    logic [3:0]  next_scan_ptr;
    logic [3:0]  scan_nxt;
    logic [3:0]  scan_eff;
    logic [3:0]  scan_after;
    logic        sample_b_phase;
    logic        next_sample_b_phase;

    // named views of the fields
    logic [4:0]  ch_zero_pos_sel_a;
    logic [4:0]  ch_zero_pos_sel_b;
    logic        ch_zero_neg_sel_a;
    logic        ch_zero_neg_sel_b;
    logic [12:0] scan_include_mask;
    logic [12:0] pin_digital_mode_bits;
    logic        alternate_sample_enable;
    logic        scan_enable;
    logic        converter_module_disable;

    assign ch_zero_pos_sel_a = channel0_input_select[AISC_POS_A_LSB +: 5];
    assign ch_zero_pos_sel_b = channel0_input_select[AISC_POS_B_LSB +: 5];
    assign ch_zero_neg_sel_a = channel0_input_select[AISC_NEG_A_BIT];
    assign ch_zero_neg_sel_b = channel0_input_select[AISC_NEG_B_BIT];
    assign scan_include_mask = input_scan_select_low[12:0];
    assign pin_digital_mode_bits    = analog_pin_config_low[12:0];
    assign alternate_sample_enable  = converter_control[AISC_ALTERNATE_SAMPLE_ENABLE_BIT];
    assign scan_enable              = converter_control[AISC_SCAN_BIT];
    assign converter_module_disable = converter_control[AISC_MDIS_BIT];

    // writes store only implemented bits; reads of an unmapped offset
    // or with no read strobe return zero so the bus never floats
    always_comb begin
        next_channel0_input_select = channel0_input_select;
        next_input_scan_select_low = input_scan_select_low;
        next_analog_pin_config_low = analog_pin_config_low;
        next_converter_control     = converter_control;
        next_reg_rdata             = 16'h0000;
        if (reg_we) begin
            unique case (reg_addr)
                AISC_OFF_CHS0: next_channel0_input_select =
                                   reg_wdata & AISC_MASK_CHS0;
                AISC_OFF_CSSL: next_input_scan_select_low =
                                   reg_wdata & AISC_MASK_CSSL;
                AISC_OFF_PIN_DIGITAL_MODE_BITS: next_analog_pin_config_low =
                                   reg_wdata & AISC_MASK_PIN_DIGITAL_MODE_BITS;
                AISC_OFF_CTRL: next_converter_control =
                                   reg_wdata & AISC_MASK_CTRL;
                default: ;
            endcase
        end
        if (reg_re) begin
            unique case (reg_addr)
                AISC_OFF_CHS0: next_reg_rdata = channel0_input_select;
                AISC_OFF_CSSL: next_reg_rdata = input_scan_select_low;
                AISC_OFF_PIN_DIGITAL_MODE_BITS: next_reg_rdata = analog_pin_config_low;
                AISC_OFF_CTRL: next_reg_rdata = converter_control;
                AISC_OFF_STAT: next_reg_rdata = {11'h000, sample_b_phase,
                                                 scan_ptr};
                default:       next_reg_rdata = 16'h0000;
            endcase
        end
    end

    // register storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            channel0_input_select <= AISC_RST_REG;
            input_scan_select_low <= AISC_RST_REG;
            analog_pin_config_low <= AISC_RST_REG;
            converter_control     <= AISC_RST_REG;
            reg_rdata             <= AISC_RST_REG;
        end else begin
            channel0_input_select <= next_channel0_input_select;
            input_scan_select_low <= next_input_scan_select_low;
            analog_pin_config_low <= next_analog_pin_config_low;
            converter_control     <= next_converter_control;
            reg_rdata             <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------------
    // sample set alternation and scan pointer
    // ------------------------------------------------------------------
    aisc_scan_next u_scan_next (
        .mask (scan_include_mask),
        .cur  (scan_ptr),
        .nxt  (scan_nxt)
    );

    // successor of the slot actually shown, so a pointer parked on a
    // cleared mask bit does not hand the same input out twice
    aisc_scan_next u_scan_after (
        .mask (scan_include_mask),
        .cur  (scan_eff),
        .nxt  (scan_after)
    );

    // clearing the alternate bit drops straight back to set A rather
    // than waiting for the next sample
    always_comb begin
        next_sample_b_phase = sample_b_phase;
        next_scan_ptr       = scan_ptr;
        if (!alternate_sample_enable) begin
            next_sample_b_phase = 1'b0;
        end else if (sample_done) begin
            next_sample_b_phase = ~sample_b_phase;
        end
        if (sample_done && !sample_b_phase && scan_enable) begin
            next_scan_ptr = scan_after;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_b_phase <= 1'b0;
            scan_ptr       <= 4'h0;
        end else begin
            sample_b_phase <= next_sample_b_phase;
            scan_ptr       <= next_scan_ptr;
        end
    end

    // ------------------------------------------------------------------
    // multiplexer selection
    // ------------------------------------------------------------------
    aisc_sel_t   next_sel;
    logic [12:0] next_pin_digital;
    logic [12:0] next_pin_read_en;
    logic [12:0] next_pin_mux_gnd;

    // a pointer left on a cleared mask bit moves on to the next one
    assign scan_eff = scan_include_mask[scan_ptr] ? scan_ptr : scan_nxt;

    always_comb begin
        next_sel = '0;
        if (sample_b_phase) begin
            next_sel.pos_code   = ch_zero_pos_sel_b;
            next_sel.neg_is_in1 = ch_zero_neg_sel_b;
        end else begin
            next_sel.neg_is_in1 = ch_zero_neg_sel_a;
            if (scan_enable) begin
                next_sel.pos_code = {1'b0, scan_eff};
            end else begin
                next_sel.pos_code = ch_zero_pos_sel_a;
            end
        end
        // absent input in a scan slot converts the low reference
        if (!sample_b_phase && scan_enable && !EXIST[scan_eff]) begin
            next_sel.pos_is_low_reference_level = 1'b1;
        end
        if (next_sel.pos_code > AISC_CODE_MAX) begin
            next_sel.code_invalid = 1'b1;
        end else if (SMALL_PKG && next_sel.pos_code >= AISC_RSV_LO
                     && next_sel.pos_code <= AISC_RSV_HI) begin
            next_sel.code_invalid = 1'b1;
        end
    end

    aisc_pin_mode u_pin_mode (
        .cfg_digital (pin_digital_mode_bits),
        .exists      (EXIST),
        .module_off  (converter_module_disable),
        .digital     (next_pin_digital),
        .read_en     (next_pin_read_en),
        .mux_gnd     (next_pin_mux_gnd)
    );

    // every output is registered; selection lags state by one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ch_zero_sel <= '0;
            sample_is_b <= 1'b0;
            pin_digital <= 13'h0000;
            pin_read_en <= 13'h0000;
            pin_mux_gnd <= 13'h0000;
        end else begin
            ch_zero_sel <= next_sel;
            sample_is_b <= sample_b_phase;
            pin_digital <= next_pin_digital;
            pin_read_en <= next_pin_read_en;
            pin_mux_gnd <= next_pin_mux_gnd;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_pos_a;
        @(posedge clk) disable iff (rst)
        (!sample_b_phase && !scan_enable)
            |=> ch_zero_sel.pos_code == $past(ch_zero_pos_sel_a);
    endproperty
    a_pos_a: assert property (p_pos_a) else $error("set A code");

    property p_pos_b;
        @(posedge clk) disable iff (rst)
        sample_b_phase |=> ch_zero_sel.pos_code == $past(ch_zero_pos_sel_b);
    endproperty
    a_pos_b: assert property (p_pos_b) else $error("set B code");

    property p_neg_a;
        @(posedge clk) disable iff (rst)
        !sample_b_phase |=> ch_zero_sel.neg_is_in1 == $past(ch_zero_neg_sel_a);
    endproperty
    a_neg_a: assert property (p_neg_a) else $error("set A neg");

    property p_neg_b;
        @(posedge clk) disable iff (rst)
        sample_b_phase |=> ch_zero_sel.neg_is_in1 == $past(ch_zero_neg_sel_b);
    endproperty
    a_neg_b: assert property (p_neg_b) else $error("set B neg");

    property p_rsvd;
        @(posedge clk) disable iff (rst)
        (reg_re && reg_addr == AISC_OFF_CHS0)
            |=> (reg_rdata & ~AISC_MASK_CHS0) == 16'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits");

    property p_alt;
        @(posedge clk) disable iff (rst)
        (alternate_sample_enable && sample_done)
            ##1 alternate_sample_enable
            |-> sample_b_phase != $past(sample_b_phase);
    endproperty
    a_alt: assert property (p_alt) else $error("no swap");

    property p_no_alt;
        @(posedge clk) disable iff (rst)
        !alternate_sample_enable |=> !sample_b_phase ##1 !sample_is_b;
    endproperty
    a_no_alt: assert property (p_no_alt) else $error("set B used");

    property p_scan_step;
        @(posedge clk) disable iff (rst)
        (scan_enable && sample_done && !sample_b_phase
         && scan_include_mask != 13'h0000 && $stable(scan_include_mask))
            |=> scan_include_mask[scan_ptr];
    endproperty
    a_scan_step: assert property (p_scan_step)
        else $error("scan lands off mask");

    property p_off_digital;
        @(posedge clk) disable iff (rst)
        converter_module_disable |=> pin_digital == EXIST;
    endproperty
    a_off_digital: assert property (p_off_digital)
        else $error("pin not digital");

    property p_pin_mode;
        @(posedge clk) disable iff (rst)
        !converter_module_disable
            |=> pin_mux_gnd == ($past(pin_digital_mode_bits) & EXIST);
    endproperty
    a_pin_mode: assert property (p_pin_mode)
        else $error("pin mode wrong");

    c_alt: cover property (@(posedge clk) disable iff (rst)
        sample_b_phase ##1 !sample_b_phase);
    c_scan: cover property (@(posedge clk) disable iff (rst)
        scan_enable && sample_done && scan_nxt < scan_ptr);
    c_low_reference_level: cover property (@(posedge clk) disable iff (rst)
        ch_zero_sel.pos_is_low_reference_level);

endmodule // aisc_top

// [verif/aisc_conv_model.sv]
// converter-side model that ends samples after a chosen delay
`timescale 1ns/1ns
module aisc_conv_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       req,
    input  wire logic [3:0] dly,
    output logic            sample_done
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;

    // a request loads the delay; delay 1 answers promptly, 4 is slow
    always_comb begin
        next_cnt = cnt;
        if (req) begin
            next_cnt = dly;
        end else if (cnt != 4'h0) begin
            next_cnt = cnt - 4'h1;
        end
    end

    // one-cycle completion pulse as the count runs out
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt         <= 4'h0;
            sample_done <= 1'b0;
        end else begin
            cnt         <= next_cnt;
            sample_done <= (cnt == 4'h1) && !req;
        end
    end
endmodule // aisc_conv_model

// [verif/aisc_top_tb.sv]
// self-checking bench for the converter input select block
`timescale 1ns/1ns
module aisc_top_tb;
    import aisc_pkg::*;

    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    logic              clk, rst, reg_we, reg_re, req, sample_done;
    logic              isb_u, isb_s, b;
    logic              re_q = 1'b0;
    logic [4:0]        reg_addr;
    logic [3:0]        dly;
    logic [15:0]       reg_wdata, rd_u, rd_s, d, exp_rd;
    logic [12:0]       dig_u, dig_s, ren_u, ren_s, gnd_u, gnd_s, m, e;
    aisc_sel_t         sel_u, sel_s;
    logic [15:0]       rd_q[$];
    int                mismatches = 0;
    int                n_checks = 0;
    int                cyc = 0;
    int                p, cur;
    int unsigned       seed;
    logic [4:0]        offs[5] = '{AISC_OFF_CHS0, AISC_OFF_CSSL,
                                   AISC_OFF_PIN_DIGITAL_MODE_BITS, AISC_OFF_CTRL, 5'h14};
    logic [15:0]       impl[5] = '{16'h9f9f, 16'h1fff, 16'h1fff,
                                   16'h8401, 16'h0000};

    aisc_top #(.SMALL_PKG(1'b0)) dut_u (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(rd_u),
        .sample_done(sample_done), .ch_zero_sel(sel_u),
        .sample_is_b(isb_u), .pin_digital(dig_u), .pin_read_en(ren_u),
        .pin_mux_gnd(gnd_u));
    // the small variant shares every input, so both see identical traffic
    aisc_top #(.SMALL_PKG(1'b1)) dut_s (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(rd_s),
        .sample_done(sample_done), .ch_zero_sel(sel_s),
        .sample_is_b(isb_s), .pin_digital(dig_s), .pin_read_en(ren_s),
        .pin_mux_gnd(gnd_s));
    aisc_conv_model conv_u (.clk(clk), .rst(rst), .req(req), .dly(dly),
        .sample_done(sample_done));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // strobes may follow back to back, so each call sets both of them
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_re <= 1'b0;
        reg_addr <= a;
        reg_wdata <= v;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        rd_q.push_back(v);
        reg_re <= 1'b1;
        reg_we <= 1'b0;
        reg_addr <= a;
    endtask

    task automatic idle();
        @(posedge clk);
        reg_we <= 1'b0;
        reg_re <= 1'b0;
    endtask

    task automatic wrs(input logic [4:0] a, input logic [15:0] v);
        wr(a, v);
        idle();
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask

    // one sample: wait for the completion pulse, then for the outputs
    task automatic smp();
        int k = 0;
        @(posedge clk);
        req <= 1'b1;
        dly <= 4'($urandom_range(1, 4));
        @(posedge clk);
        req <= 1'b0;
        do begin
            @(posedge clk);
            k++;
        end while (sample_done !== 1'b1 && k < 20);
        if (k >= 20) mismatches++;
        tick(1);
    endtask

    function automatic aisc_sel_t exp_sel(input logic [4:0] c,
                                          input logic n, input logic sml);
        aisc_sel_t s;
        s.pos_code     = c;
        s.neg_is_in1   = n;
        s.pos_is_low_reference_level = 1'b0;
        s.code_invalid = (c > 5'h0c) || (sml && c >= 5'h06 && c <= 5'h08);
        return s;
    endfunction

    function automatic int nxt(input logic [12:0] mk, input int q,
                               input int off);
        int j;
        for (int k = 0; k < 13; k++) begin
            j = (q + off + k) % 13;
            if (mk[j]) return j;
        end
        return q;
    endfunction

    // ------------------------------------------------------------------
    // clock, read monitor and hang guard
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // read data stands only in the cycle after the strobe, zero otherwise
    always @(posedge clk) re_q <= reg_re;
    always @(negedge clk) begin
        if (re_q) begin
            exp_rd = rd_q.pop_front();
            check(rd_u, exp_rd);
            check(rd_s, exp_rd);
        end else if (!rst) begin
            check(rd_u, 16'h0000);
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = $urandom(32'h031e);
        rst = 1'b1;
        reg_we = 1'b0;
        reg_re = 1'b0;
        req = 1'b0;
        dly = 4'h1;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        do_reset();
        // reset values, unimplemented bits and an unmapped offset
        for (int i = 0; i < 5; i++) rd(offs[i], 16'h0000);
        for (int i = 0; i < 5; i++) wr(offs[i], 16'hffff);
        for (int i = 0; i < 5; i++) rd(offs[i], impl[i]);
        wrs(AISC_OFF_CTRL, 16'h0000);
        // every positive code, plus codes beyond the last input
        for (int i = 0; i < 16; i++) begin
            d = 16'($urandom);
            d[4:0] = (i == 15) ? 5'h1f : 5'(i);
            wr(AISC_OFF_CHS0, d);
            rd(AISC_OFF_CHS0, d & 16'h9f9f);
            idle();
            tick(1);
            check(16'(sel_u), 16'(exp_sel(d[4:0], d[7], 1'b0)));
            check(16'(sel_s), 16'(exp_sel(d[4:0], d[7], 1'b1)));
            check(16'(isb_u), 16'h0000);
        end
        // alternating sets A and B, ending in set B before turning off
        d = 16'($urandom);
        wrs(AISC_OFF_CHS0, d);
        wrs(AISC_OFF_CTRL, 16'h0001);
        for (int i = 1; i <= 5; i++) begin
            smp();
            b = i[0];
            check(16'(sel_u), 16'(b ? exp_sel(d[12:8], d[15], 1'b0)
                                    : exp_sel(d[4:0], d[7], 1'b0)));
            check(16'(isb_u), 16'(b));
            check(16'(isb_s), 16'(b));
        end
        wrs(AISC_OFF_CTRL, 16'h0000);
        tick(2);
        check(16'(sel_u), 16'(exp_sel(d[4:0], d[7], 1'b0)));
        check(16'(isb_u), 16'h0000);
        // scanning after a second reset, several random masks
        do_reset();
        wrs(AISC_OFF_CHS0, 16'h000c);
        p = 0;
        for (int r = 0; r < 3; r++) begin
            m = 13'($urandom) | (13'h1 << $urandom_range(0, 12));
            wrs(AISC_OFF_CSSL, {3'($urandom), m});
            wrs(AISC_OFF_CTRL, 16'h0400);
            tick(1);
            for (int s = 0; s < 7; s++) begin
                if (s > 0) smp();
                if (s > 0) p = nxt(m, cur, 1);
                cur = nxt(m, p, 0);
                check(16'(sel_u.pos_code), 16'(cur));
                check(16'(sel_s.pos_is_low_reference_level), 16'(cur inside {6, 7, 8}));
            end
            // status shows the pointer parked on the next slot to convert
            rd(AISC_OFF_STAT, 16'(p));
            idle();
        end
        // pin modes, with the converter enabled and disabled in turn
        for (int i = 0; i < 4; i++) begin
            d = 16'($urandom);
            wrs(AISC_OFF_CTRL, {i[0], 15'h0000});
            wrs(AISC_OFF_PIN_DIGITAL_MODE_BITS, d);
            tick(1);
            e = i[0] ? 13'h1fff : d[12:0];
            check(16'(dig_u), 16'(e & AISC_EXIST_BIG));
            check(16'(ren_u), 16'(e & AISC_EXIST_BIG));
            check(16'(gnd_u), 16'(e & AISC_EXIST_BIG));
            check(16'(dig_s), 16'(e & AISC_EXIST_SML));
            check(16'(ren_s), 16'(e & AISC_EXIST_SML));
            check(16'(gnd_s), 16'(e & AISC_EXIST_SML));
        end
        tick(2);
        results();
    end
endmodule // aisc_top_tb
